/* File: design/pwm_pkg.sv */
/*
 * constants for the six channel pwm register core: offsets, fields,
 * reset values. assumes an 8-bit special function bus with byte offsets.
 */
package pwm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] OFS_PERIOD_LOW = 8'hD9;
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'hD1;
  localparam logic [7:0] OFS_ROUTE_A = 8'hDE;
  localparam logic [7:0] OFS_RUN_CONTROL = 8'hD8;
  localparam logic [7:0] OFS_PRESCALE = 8'hDF;
  localparam int NUM_CHAN = 6;
  localparam logic [7:0] OFS_DUTY_LOW [NUM_CHAN] = '{
    8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hCC, 8'hCD};
  localparam logic [7:0] OFS_DUTY_HIGH [NUM_CHAN] = '{
    8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hC4, 8'hC5};
  // first channel that lives in the alternate page
  localparam int PAGED_CHAN_FIRST = 4;
  // ==========================================================
  // field positions
  localparam int CKS_BIT = 6;
  localparam int RUN_BIT = 7;
  localparam int LOAD_BIT = 6;
  localparam int CLR_BIT = 4;
  localparam int DIV_W = 3;
  localparam int CNT_W = 16;
  localparam int DIV_CNT_W = 7;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [DIV_W-1:0] RST_DIV = 3'h0;
  localparam logic [DIV_CNT_W-1:0] RST_DIV_CNT = 7'h00;
  // ==========================================================
  // load handshake states
  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_WAIT = 2'b10
  } load_state_t;
endpackage : pwm_pkg

/* File: design/pwm_prescaler.sv */
/*
 * count enable for the pwm counter: source select and 2^n divider.
 * assumes the timer overflow strobe is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic sel_timer,
  input wire logic [DIV_W-1:0] div_code,
  input wire logic timer1_ovf,
  // result
  output logic tick
);
  logic [DIV_CNT_W-1:0] div_q, div_d;
  logic src_en;
  logic last;

  function automatic logic [DIV_CNT_W-1:0] div_limit(input logic [DIV_W-1:0] c);
    div_limit = DIV_CNT_W'((8'h01 << c) - 8'h01);
  endfunction : div_limit

  always_comb begin
    src_en = sel_timer ? timer1_ovf : 1'b1;
    last = (div_q >= div_limit(div_code));
    tick = run && src_en && last;
    div_d = div_q;
    if (!run) begin
      div_d = RST_DIV_CNT;
    end else if (src_en) begin
      div_d = last ? RST_DIV_CNT : div_q + DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_q <= RST_DIV_CNT;
    end else begin
      div_q <= div_d;
    end
  end
endmodule : pwm_prescaler
`default_nettype wire

/* File: design/pwm_channel.sv */
/*
 * one edge-aligned generator signal: set at count zero, cleared on
 * duty match. assumes count_next is the value the counter takes on tick.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // counter side
  input wire logic tick,
  input wire logic [CNT_W-1:0] count_next,
  input wire logic [CNT_W-1:0] duty,
  // result
  output logic gen
);
  logic gen_q, gen_d;

  always_comb begin
    gen_d = gen_q;
    if (tick) begin
      if (count_next == duty) begin
        gen_d = 1'b0;
      end else if (count_next == RST_WORD) begin
        gen_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gen_q <= 1'b0;
    end else begin
      gen_q <= gen_d;
    end
  end

  assign gen = gen_q;
endmodule : pwm_channel
`default_nettype wire

/* File: design/pwm_core.sv */
/*
 * six channel pwm core: register file, double buffered period and
 * duty, 16-bit up counter, generator signals and pin routing.
 * assumes a single-cycle register port on clk_sys and a page level
 * driven by the cpu; gpio values come from the port logic.
 */
// Summary of operation
// - count clock is system clock, or timer overflow when source bit set
// - period is sixteen bits from a low and a high byte register
// - six channels each hold a sixteen-bit duty from two bytes
// - route bits 0..5 put channel outputs on pins instead of gpio
// - reset clears clock, period, duty and route registers to zero
// - duty bytes of channels 4 and 5 only reachable in page 1
// - counter runs 0..period; output set at zero, cleared on duty match
// - period and duty load at period end on request; request self-clears
// - counter stays idle while run enable is low
// - prescale code divides source by 1 up to 128 in powers of two
`timescale 1ns/1ps
`default_nettype none
module pwm_core
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic page1_sel,
  // timer side
  input wire logic timer1_ovf,
  // shared pins
  input wire logic [NUM_CHAN-1:0] gpio_out,
  input wire logic [NUM_CHAN-1:0] gpio_oe_n,
  output logic [NUM_CHAN-1:0] pin_out,
  output logic [NUM_CHAN-1:0] pin_oe_n,
  output logic [NUM_CHAN-1:0] gen_signal
);
  // ==========================================================
  // state
  logic cks_q, cks_d;
  logic [CNT_W-1:0] per_sh_q, per_sh_d;
  logic [CNT_W-1:0] per_act_q, per_act_d;
  logic [CNT_W-1:0] duty_sh_q [NUM_CHAN];
  logic [CNT_W-1:0] duty_sh_d [NUM_CHAN];
  logic [CNT_W-1:0] duty_act_q [NUM_CHAN];
  logic [CNT_W-1:0] duty_act_d [NUM_CHAN];
  logic [NUM_CHAN-1:0] route_q, route_d;
  logic run_q, run_d;
  logic clr_q, clr_d;
  logic [DIV_W-1:0] div_q, div_d;
  load_state_t load_q, load_d;
  logic [7:0] rdata_q, rdata_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [NUM_CHAN-1:0] pin_q, pin_d;
  logic [NUM_CHAN-1:0] oe_n_q, oe_n_d;
  logic tick;
  logic period_end;
  logic [NUM_CHAN-1:0] gen;

  // ==========================================================
  // address decode
  // paged duty bytes answer only with the page selected
  function automatic logic reachable(input logic [7:0] a, input logic pg);
    reachable = 1'b1;
    for (int i = PAGED_CHAN_FIRST; i < NUM_CHAN; i++) begin
      if ((a == OFS_DUTY_LOW[i]) || (a == OFS_DUTY_HIGH[i])) begin
        reachable = pg;
      end
    end
  endfunction : reachable

  // ==========================================================
  // register file
  always_comb begin
    cks_d = cks_q;
    per_sh_d = per_sh_q;
    duty_sh_d = duty_sh_q;
    route_d = route_q;
    run_d = run_q;
    div_d = div_q;
    rdata_d = RST_BYTE;
    if (reg_wr && reachable(reg_addr, page1_sel)) begin
      case (reg_addr)
        OFS_CLOCK_CONTROL: begin
          cks_d = reg_wdata[CKS_BIT];
        end
        OFS_PERIOD_LOW: begin
          per_sh_d[7:0] = reg_wdata;
        end
        OFS_PERIOD_HIGH: begin
          per_sh_d[15:8] = reg_wdata;
        end
        OFS_ROUTE_A: begin
          route_d = reg_wdata[NUM_CHAN-1:0];
        end
        OFS_RUN_CONTROL: begin
          run_d = reg_wdata[RUN_BIT];
        end
        OFS_PRESCALE: begin
          div_d = reg_wdata[DIV_W-1:0];
        end
        default: begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            if (reg_addr == OFS_DUTY_LOW[i]) begin
              duty_sh_d[i][7:0] = reg_wdata;
            end
            if (reg_addr == OFS_DUTY_HIGH[i]) begin
              duty_sh_d[i][15:8] = reg_wdata;
            end
          end
        end
      endcase
    end
    if (reg_rd && reachable(reg_addr, page1_sel)) begin
      case (reg_addr)
        OFS_CLOCK_CONTROL: begin
          rdata_d[CKS_BIT] = cks_q;
        end
        OFS_PERIOD_LOW: begin
          rdata_d = per_sh_q[7:0];
        end
        OFS_PERIOD_HIGH: begin
          rdata_d = per_sh_q[15:8];
        end
        OFS_ROUTE_A: begin
          rdata_d[NUM_CHAN-1:0] = route_q;
        end
        OFS_RUN_CONTROL: begin
          rdata_d[RUN_BIT] = run_q;
          rdata_d[LOAD_BIT] = (load_q == LD_WAIT);
          rdata_d[CLR_BIT] = clr_q;
        end
        OFS_PRESCALE: begin
          rdata_d[DIV_W-1:0] = div_q;
        end
        default: begin
          for (int i = 0; i < NUM_CHAN; i++) begin
            if (reg_addr == OFS_DUTY_LOW[i]) begin
              rdata_d = duty_sh_q[i][7:0];
            end
            if (reg_addr == OFS_DUTY_HIGH[i]) begin
              rdata_d = duty_sh_q[i][15:8];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cks_q <= 1'b0;
      per_sh_q <= RST_WORD;
      for (int i = 0; i < NUM_CHAN; i++) begin
        duty_sh_q[i] <= RST_WORD;
      end
      route_q <= RST_BYTE[NUM_CHAN-1:0];
      run_q <= 1'b0;
      div_q <= RST_DIV;
      rdata_q <= RST_BYTE;
    end else begin
      cks_q <= cks_d;
      per_sh_q <= per_sh_d;
      duty_sh_q <= duty_sh_d;
      route_q <= route_d;
      run_q <= run_d;
      div_q <= div_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // count enable
  pwm_prescaler u_presc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(run_q),
    .sel_timer(cks_q),
    .div_code(div_q),
    .timer1_ovf(timer1_ovf),
    .tick(tick)
  );

  // ==========================================================
  // counter, load and clear handshakes
  logic wr_ctl;
  assign wr_ctl = reg_wr && (reg_addr == OFS_RUN_CONTROL);
  assign period_end = tick && (cnt_q >= per_act_q);

  always_comb begin
    cnt_d = cnt_q;
    per_act_d = per_act_q;
    duty_act_d = duty_act_q;
    load_d = load_q;
    clr_d = clr_q;
    if (clr_q) begin
      cnt_d = RST_WORD;
      clr_d = 1'b0;
    end else if (tick) begin
      cnt_d = period_end ? RST_WORD : cnt_q + CNT_W'(1);
    end
    case (load_q)
      LD_IDLE: begin
        if (wr_ctl && reg_wdata[LOAD_BIT]) begin
          load_d = LD_WAIT;
        end
      end
      LD_WAIT: begin
        if (period_end) begin
          per_act_d = per_sh_q;
          duty_act_d = duty_sh_q;
          load_d = LD_IDLE;
        end
      end
      default: begin
        load_d = LD_IDLE;
      end
    endcase
    // a new request in the completing cycle stays pending
    if (wr_ctl && reg_wdata[LOAD_BIT]) begin
      load_d = LD_WAIT;
    end
    if (wr_ctl && reg_wdata[CLR_BIT]) begin
      clr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= RST_WORD;
      per_act_q <= RST_WORD;
      for (int i = 0; i < NUM_CHAN; i++) begin
        duty_act_q[i] <= RST_WORD;
      end
      load_q <= LD_IDLE;
      clr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      per_act_q <= per_act_d;
      duty_act_q <= duty_act_d;
      load_q <= load_d;
      clr_q <= clr_d;
    end
  end

  // ==========================================================
  // generator signals
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    pwm_channel u_chan (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .tick(tick && !clr_q),
      .count_next(cnt_d),
      .duty(duty_act_d[g]),
      .gen(gen[g])
    );
  end

  assign gen_signal = gen;

  // ==========================================================
  // pin multiplexer
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      pin_d[i] = route_q[i] ? gen[i] : gpio_out[i];
      oe_n_d[i] = route_q[i] ? 1'b0 : gpio_oe_n[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_q <= RST_BYTE[NUM_CHAN-1:0];
      oe_n_q <= {NUM_CHAN{1'b1}};
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_n = oe_n_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  reset_clears_a: assert property (disable iff (1'b0) sys_rst |=>
    (cks_q == 1'b0 && per_sh_q == RST_WORD && route_q == '0 && duty_sh_q[5] == RST_WORD))
    else $error("registers not cleared by reset");
  sys_clock_count_a: assert property (
    (run_q && !cks_q && div_q == RST_DIV && !clr_q && cnt_q < per_act_q)
    |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not advance on system clock");
  timer_enable_a: assert property ((cks_q && !timer1_ovf) |-> !tick)
    else $error("tick without timer overflow");
  period_load_a: assert property (
    (load_q == LD_WAIT && period_end) |=> per_act_q == $past(per_sh_q))
    else $error("period not transferred at period end");
  duty_load_a: assert property (
    (load_q == LD_WAIT && period_end) |=> duty_act_q[4] == $past(duty_sh_q[4]))
    else $error("duty not transferred at period end");
  load_self_clear_a: assert property (
    (load_q == LD_WAIT && period_end && !wr_ctl) |=> load_q == LD_IDLE)
    else $error("load request not cleared");
  hold_active_a: assert property (
    (load_q == LD_IDLE) |=> $stable(per_act_q))
    else $error("active period changed without load");
  wrap_zero_a: assert property ((period_end && !clr_q) |=> cnt_q == RST_WORD)
    else $error("counter did not wrap to zero");
  idle_stop_a: assert property ((!run_q && !clr_q) |=> $stable(cnt_q))
    else $error("counter moved while idle");
  page_gate_a: assert property (
    (reg_rd && !page1_sel && reg_addr == OFS_DUTY_HIGH[4]) |=> reg_rdata == RST_BYTE)
    else $error("paged register visible outside page 1");
  route_pin_a: assert property (route_q[0] |=> pin_out[0] == $past(gen[0]))
    else $error("routed pin does not follow generator");
  slow_div_a: assert property (
    (tick && div_q == 3'h7 && $stable(div_q) && run_q) |=> (!tick || div_q != 3'h7) [*8])
    else $error("divide by 128 ticked too soon");
  route_oe_a: assert property (route_q[1] |=> !pin_oe_n[1])
    else $error("routed pin not driven");
  gpio_pass_a: assert property (!route_q[2] |=> pin_out[2] == $past(gpio_out[2]))
    else $error("unrouted pin does not follow gpio");
  clear_restart_a: assert property (
    (clr_q && !wr_ctl) |=> (cnt_q == RST_WORD && !clr_q))
    else $error("counter clear not applied");
  clear_hold_a: assert property (clr_q |=> $stable(gen))
    else $error("generator moved during counter clear");

  load_done_c: cover property (load_q == LD_WAIT ##[1:300] load_q == LD_IDLE);
  clear_c: cover property (clr_q ##1 tick);
  gen_high_c: cover property ($rose(gen[0]) ##[1:300] $fell(gen[0]));
  timer_src_c: cover property (cks_q && tick);
endmodule : pwm_core
`default_nettype wire

/* File: bench/pin_side_model.sv */
/*
 * port logic and timer stand-in beside the pwm core.
 * assumes one clock; everything changes just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
  // clock
  input wire logic clk_sys,
  // timer control
  input wire logic ovf_en,
  // outputs
  output logic [5:0] gpio_out,
  output logic [5:0] gpio_oe_n,
  output logic timer1_ovf
);
  logic [5:0] data_q = 6'h15;
  logic [5:0] oe_n_q = 6'h2A;
  logic ovf_q = 1'b0;
  logic [1:0] gap_q = 2'h0;
  assign gpio_out = data_q;
  assign gpio_oe_n = oe_n_q;
  assign timer1_ovf = ovf_q;
  // ==========================================================
  // port data moves every cycle so a stale copy shows up
  always @(posedge clk_sys) begin
    data_q <= data_q + 6'h0B;
    oe_n_q <= ~oe_n_q;
    gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
    ovf_q <= ovf_en && (gap_q == 2'h2);
  end
endmodule : pin_side_model
`default_nettype wire

/* File: bench/six_channel_pwm_period_duty_regs_tb.sv */
/*
 * self-checking bench for the six channel pwm core.
 * assumes pwm_core and the pin side model; one 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module six_channel_pwm_period_duty_regs_tb
  import pwm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic page1_sel = 1'b0;
  logic ovf_en = 1'b0;
  logic [7:0] reg_rdata;
  logic timer1_ovf;
  logic [5:0] gpio_out, gpio_oe_n, pin_out, pin_oe_n, gen_signal;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] duty [6] = '{16'h0001, 16'h0002, 16'h0000, 16'h0005, 16'h0003, 16'h0102};
  localparam logic [15:0] PER = 16'h0003;

  pwm_core pwm_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .page1_sel(page1_sel), .timer1_ovf(timer1_ovf), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gen_signal(gen_signal));
  pin_side_model pin_side_model_inst (.clk_sys(clk_sys), .ovf_en(ovf_en),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .timer1_ovf(timer1_ovf));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // helpers
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rd_chk
  // high cycles of one generator over n cycles
  task automatic meas(input int ch, input int n, input int exp);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 if (gen_signal[ch] === 1'b1) hi++;
    end
    check(16'(hi), 16'(exp));
  endtask : meas
  task automatic load_run;
    logic [7:0] d;
    wr(OFS_RUN_CONTROL, 8'hC0);
    repeat (40) begin
      rd(OFS_RUN_CONTROL, d);
      if (d[LOAD_BIT] === 1'b0) break;
    end
    check({15'h0000, d[LOAD_BIT]}, 16'h0000);
  endtask : load_run
  function automatic int hi_per(input logic [15:0] d);
    return (d > PER) ? int'(PER) + 1 : int'(d);
  endfunction : hi_per
  // ==========================================================
  // scenarios
  task automatic t_reset;
    page1_sel <= 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      rd_chk(OFS_DUTY_LOW[i], 8'h00);
      rd_chk(OFS_DUTY_HIGH[i], 8'h00);
    end
    rd_chk(OFS_CLOCK_CONTROL, 8'h00);
    rd_chk(OFS_PERIOD_LOW, 8'h00);
    rd_chk(OFS_PERIOD_HIGH, 8'h00);
    rd_chk(OFS_ROUTE_A, 8'h00);
    rd_chk(OFS_RUN_CONTROL, 8'h00);
    rd_chk(OFS_PRESCALE, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    @(posedge clk_sys);
    page1_sel <= 1'b0;
    wr(OFS_DUTY_LOW[4], 8'hAA);
    rd_chk(OFS_DUTY_LOW[4], 8'h00);
    @(posedge clk_sys);
    page1_sel <= 1'b1;
    rd_chk(OFS_DUTY_LOW[4], 8'h00);
    wr(8'h80, 8'h5A);
    rd_chk(8'h80, 8'h00);
    wr(OFS_CLOCK_CONTROL, 8'hFF);
    rd_chk(OFS_CLOCK_CONTROL, 8'h40);
    wr(OFS_CLOCK_CONTROL, 8'h00);
    wr(OFS_PERIOD_LOW, PER[7:0]);
    wr(OFS_PERIOD_HIGH, 8'hA5);
    rd_chk(OFS_PERIOD_HIGH, 8'hA5);
    wr(OFS_PERIOD_HIGH, PER[15:8]);
    rd_chk(OFS_PERIOD_LOW, PER[7:0]);
    for (int i = 0; i < NUM_CHAN; i++) begin
      wr(OFS_DUTY_LOW[i], duty[i][7:0]);
      wr(OFS_DUTY_HIGH[i], duty[i][15:8]);
      rd_chk(OFS_DUTY_LOW[i], duty[i][7:0]);
      rd_chk(OFS_DUTY_HIGH[i], duty[i][15:8]);
    end
    $display("test registers done");
  endtask : t_regs
  task automatic t_wave;
    meas(0, 20, 0);
    load_run();
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < NUM_CHAN; i++) begin
      meas(i, 40, 10 * hi_per(duty[i]));
    end
    wr(OFS_DUTY_LOW[0], 8'h03);
    meas(0, 40, 10 * hi_per(duty[0]));
    duty[0] = 16'h0003;
    load_run();
    repeat (8) @(posedge clk_sys);
    meas(0, 40, 10 * hi_per(duty[0]));
    $display("test waveform done");
  endtask : t_wave
  // counter restarts at zero two edges after the clear write
  task automatic t_clear;
    logic [7:0] d;
    wr(OFS_RUN_CONTROL, 8'h90);
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      #1 check({15'h0000, gen_signal[0]}, {15'h0000, k != 0});
    end
    rd(OFS_RUN_CONTROL, d);
    check({8'h00, d}, 16'h0080);
    @(posedge clk_sys);
    #1 check({8'h00, reg_rdata}, 16'h0000);
    $display("test counter clear done");
  endtask : t_clear
  task automatic t_div;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_PRESCALE, 8'(c));
      repeat (8 << c) @(posedge clk_sys);
      meas(1, 16 << c, 4 * hi_per(duty[1]) << c);
    end
    wr(OFS_PRESCALE, 8'h00);
    $display("test prescale done");
  endtask : t_div
  task automatic t_timer;
    ovf_en <= 1'b1;
    wr(OFS_CLOCK_CONTROL, 8'h40);
    repeat (24) @(posedge clk_sys);
    meas(1, 48, 12 * hi_per(duty[1]));
    @(posedge clk_sys);
    ovf_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    meas(1, 30, gen_signal[1] === 1'b1 ? 30 : 0);
    wr(OFS_CLOCK_CONTROL, 8'h00);
    $display("test timer source done");
  endtask : t_timer
  task automatic t_route(input logic [5:0] sel);
    logic [5:0] g, o, s;
    wr(OFS_ROUTE_A, {2'b00, sel});
    repeat (2) @(posedge clk_sys);
    repeat (12) begin
      #1 g = gpio_out;
      o = gpio_oe_n;
      s = gen_signal;
      @(posedge clk_sys);
      #1 check({10'h000, pin_out}, {10'h000, (s & sel) | (g & ~sel)});
      check({10'h000, pin_oe_n}, {10'h000, o & ~sel});
    end
    $display("test routing done");
  endtask : t_route
  // ==========================================================
  // main sequence
  initial begin
    repeat (15) @(posedge clk_sys);
    #1 check({10'h000, pin_oe_n}, 16'h003F);
    check({10'h000, gen_signal}, 16'h0000);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_wave();
    t_clear();
    t_div();
    t_timer();
    t_route(6'h01);
    t_route(6'h3F);
    end_sim();
  end
endmodule : six_channel_pwm_period_duty_regs_tb
`default_nettype wire
